//--- bench/freq_select_watchdog_recovery_chk.sv
// Purpose : Port-level checks for frequency select and watchdog recovery
// Assumes : Watches only the top module's ports
// Notes   : Attached to the top module by bind
`timescale 1ns/1ps
module freq_select_watchdog_recovery_chk (
    input wire logic                       ref_clk,
    input wire logic                       reset_n,
    input wire freq_ctl_pkg::reg_req_type  reg_req,
    input wire logic [7:0]                 reg_rdata,
    input wire freq_ctl_pkg::freq_out_type freq_out,
    input wire logic                       recovery_active,
    input wire logic                       sys_reset_n
);
    logic wd_on_q;
    logic wd_on_d;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // ------------------------------------------------------------
    // Watchdog enable as last written
    // ------------------------------------------------------------
    always_comb begin
        wd_on_d = wd_on_q;
        if (reg_req.wr && reg_req.addr == freq_ctl_pkg::OFS_WDOG) begin
            wd_on_d = reg_req.wdata[7];
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wd_on_q <= 1'b0;
        end else begin
            wd_on_q <= wd_on_d;
        end
    end
    property p_test_byte;
        reg_req.rd && reg_req.addr == freq_ctl_pkg::OFS_TEST |=> reg_rdata == 8'h03;
    endproperty
    a_test_byte: assert property (p_test_byte) else $error("test byte read wrong");
    property p_rsvd_read;
        reg_req.rd && (reg_req.addr == freq_ctl_pkg::OFS_RSVD_A || reg_req.addr == freq_ctl_pkg::OFS_RSVD_B)
            |=> reg_rdata == 8'h00;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved byte not zero");
    property p_rst_pulse;
        $fell(sys_reset_n) |-> (!sys_reset_n)[*8] ##1 (!sys_reset_n)[*8] ##1 sys_reset_n;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("system reset pulse length wrong");
    property p_recovery_on_expiry;
        $fell(sys_reset_n) |-> ##[0:2] recovery_active;
    endproperty
    a_recovery_on_expiry: assert property (p_recovery_on_expiry) else $error("no recovery on expiry");
    property p_expiry_enabled;
        $fell(sys_reset_n) |-> wd_on_q;
    endproperty
    a_expiry_enabled: assert property (p_expiry_enabled) else $error("expiry while disabled");
    property p_bypass_decode;
        reg_req.wr && reg_req.addr == freq_ctl_pkg::OFS_SELECT && reg_req.wdata[7] && !freq_out.prog_mode
            |-> ##2 freq_out.cpu_freq == freq_ctl_pkg::CPU_TABLE[$past(reg_req.wdata[4:0], 2)];
    endproperty
    a_bypass_decode: assert property (p_bypass_decode) else $error("register code not decoded");
    property p_gear;
        $past(reset_n) |-> freq_out.gear == freq_ctl_pkg::GEAR_CONST;
    endproperty
    a_gear: assert property (p_gear) else $error("gear constant wrong");
    property p_flag_in_pulse;
        reg_req.rd && reg_req.addr == freq_ctl_pkg::OFS_WDOG && !sys_reset_n |=> reg_rdata[6];
    endproperty
    a_flag_in_pulse: assert property (p_flag_in_pulse) else $error("time-out flag not set");
    property p_w1c;
        reg_req.wr && reg_req.addr == freq_ctl_pkg::OFS_WDOG && reg_req.wdata[6] && !reg_req.wdata[7]
            ##[1:6] (reg_req.rd && reg_req.addr == freq_ctl_pkg::OFS_WDOG) |=> !reg_rdata[6];
    endproperty
    a_w1c: assert property (p_w1c) else $error("time-out flag not cleared");
endmodule
bind freq_select_watchdog_recovery freq_select_watchdog_recovery_chk chk (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .freq_out(freq_out), .recovery_active(recovery_active), .sys_reset_n(sys_reset_n)
);

//--- bench/host_model.sv
// Purpose : Management host issuing byte reads and writes
// Assumes : Requests taken on the edge after they are driven
// Notes   : Released address and data show the inverse of the last value
`timescale 1ns/1ps
module host_model (
    input  wire logic                 ref_clk,
    output freq_ctl_pkg::reg_req_type reg_req
);
    initial reg_req = '0;
    task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_req = {w, !w, a, d};
        @(posedge ref_clk);
        #1;
        reg_req = {2'b00, ~a, ~d};
    endtask
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == freq_ctl_pkg::OFS_TEST) begin
            v[1:0] = 2'b11;
        end
        put(1'b1, a, v);
    endtask
    task automatic arm_then_change(input logic [7:0] wd, input logic [7:0] sel);
        write_byte(freq_ctl_pkg::OFS_WDOG, wd | 8'h80);
        write_byte(freq_ctl_pkg::OFS_SELECT, sel);
    endtask
endmodule

//--- bench/tb_freq_select_watchdog_recovery.sv
// Purpose : Self-checking bench for frequency select and watchdog recovery
// Assumes : Watchdog ticks shortened to 4 and 8 cycles
// Notes   : Read results are compared from a queue of expected bytes
`timescale 1ns/1ps
module tb_freq_select_watchdog_recovery;
    logic                       ref_clk;
    logic                       reset_n;
    logic [4:0]                 strap_select_pins;
    freq_ctl_pkg::reg_req_type  reg_req;
    logic [7:0]                 reg_rdata;
    freq_ctl_pkg::freq_out_type freq_out;
    logic                       recovery_active;
    logic                       sys_reset_n;
    logic [7:0]                 exp_q[$];
    logic [7:0]                 n_v;
    logic [7:0]                 m_v;
    logic [4:0]                 code;
    integer                     seed;
    int                         err_total = 0;
    int                         cmp_count = 0;
    freq_select_watchdog_recovery #(.SHORT_CYCLES(4), .LONG_CYCLES(8)) dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .strap_select_pins(strap_select_pins), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .freq_out(freq_out), .recovery_active(recovery_active), .sys_reset_n(sys_reset_n)
    );
    host_model host (.ref_clk(ref_clk), .reg_req(reg_req));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] a);
        cmp_count++;
        if (a !== e) begin
            err_total++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.put(1'b0, a, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.write_byte(a, d);
        settle();
    endtask
    task automatic fchk(input logic [4:0] c);
        chk(32'(freq_ctl_pkg::CPU_TABLE[c]), 32'(freq_out.cpu_freq));
        chk(32'(freq_ctl_pkg::MID_TABLE[c]), 32'(freq_out.mid_freq));
        chk(32'(freq_ctl_pkg::PCI_TABLE[c]), 32'(freq_out.pci_freq));
        chk(32'h0, 32'(freq_out.prog_mode));
    endtask
    task automatic wait_rst(input logic lvl);
        for (int n = 0; n < 200 && sys_reset_n !== lvl; n++) begin
            @(posedge ref_clk);
            #1;
        end
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (10000) @(posedge ref_clk);
        err_total++;
        complete_run();
    end
    initial begin
        forever begin
            @(posedge ref_clk);
            if (reg_req.rd === 1'b1) begin
                @(posedge ref_clk);
                #2;
                chk(32'(exp_q.pop_front()), 32'(reg_rdata));
            end
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'h66d6;
        reset_n = 1'b0;
        code = 5'($random(seed));
        strap_select_pins = code;
        repeat (16) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        settle();
        strap_select_pins = ~code;
        fchk(code);
        rd(freq_ctl_pkg::OFS_TEST, 8'h03);
        rd(freq_ctl_pkg::OFS_RSVD_A, 8'h00);
        rd(freq_ctl_pkg::OFS_RSVD_B, 8'h00);
        rd(8'h40 | 8'($random(seed) & 8'h3F), 8'h00);
        host.write_byte(freq_ctl_pkg::OFS_TEST, 8'hFC);
        rd(freq_ctl_pkg::OFS_TEST, 8'h03);
        for (int i = 0; i < 32; i++) begin
            wr(freq_ctl_pkg::OFS_SELECT, 8'h80 | 8'(i));
            fchk(5'(i));
        end
        wr(freq_ctl_pkg::OFS_SELECT, 8'h00);
        fchk(code);
        n_v = 8'($random(seed));
        m_v = 8'($random(seed)) & 8'h7F;
        wr(freq_ctl_pkg::OFS_CPU_N, n_v);
        wr(freq_ctl_pkg::OFS_CPU_M, 8'h80 | m_v);
        chk(32'h1, 32'(freq_out.prog_mode));
        chk(32'(n_v), 32'(freq_out.pll_n));
        chk(32'(m_v), 32'(freq_out.pll_m));
        wr(freq_ctl_pkg::OFS_CPU_M, 8'h00);
        wr(freq_ctl_pkg::OFS_WDOG, 8'h02);
        wr(freq_ctl_pkg::OFS_SELECT, 8'h00);
        repeat (20) settle();
        chk(32'h1, 32'(sys_reset_n));
        host.arm_then_change(8'h1F, 8'h00);
        repeat (5) settle();
        wr(freq_ctl_pkg::OFS_WDOG, 8'h00);
        repeat (100) settle();
        chk(32'h1, 32'(sys_reset_n));
        host.arm_then_change(8'h02, 8'h80 | 8'(~code));
        wait_rst(1'b0);
        chk(32'h0, 32'(sys_reset_n));
        rd(freq_ctl_pkg::OFS_WDOG, 8'hC2);
        rd(freq_ctl_pkg::OFS_STATUS, {2'h3, 1'b0, code});
        chk(32'h1, 32'(recovery_active));
        fchk(code);
        wait_rst(1'b1);
        chk(32'h1, 32'(sys_reset_n));
        wr(freq_ctl_pkg::OFS_WDOG, 8'h00);
        rd(freq_ctl_pkg::OFS_WDOG, 8'h40);
        wr(freq_ctl_pkg::OFS_WDOG, 8'h40);
        rd(freq_ctl_pkg::OFS_WDOG, 8'h00);
        n_v = 8'($random(seed));
        m_v = 8'($random(seed)) & 8'h7F;
        wr(freq_ctl_pkg::OFS_RCV_N, n_v);
        wr(freq_ctl_pkg::OFS_RCV_M, 8'h80 | m_v);
        host.arm_then_change(8'hA2, 8'h00);
        wait_rst(1'b0);
        settle();
        chk(32'h1, 32'(freq_out.prog_mode));
        chk(32'(n_v), 32'(freq_out.pll_n));
        chk(32'(m_v), 32'(freq_out.pll_m));
        wait_rst(1'b1);
        wr(freq_ctl_pkg::OFS_WDOG, 8'h40);
        wr(freq_ctl_pkg::OFS_SELECT, 8'h00);
        chk(32'h0, 32'(recovery_active));
        fchk(code);
        repeat (4) @(posedge ref_clk);
        complete_run();
    end
endmodule

//--- hdl/freq_ctl_pkg.sv
// Purpose : Shared constants, tables and carriers for frequency select and watchdog recovery
// Assumes : 200 MHz ref_clk, byte-wide control register port
// Notes   : Frequencies are in units of 100 kHz
package freq_ctl_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MHZ         = 200;
    localparam int unsigned CLK_PERIOD_NS   = 5;
    localparam int unsigned WD_SHORT_MS     = 150;
    localparam int unsigned WD_LONG_MS      = 2500;
    localparam int unsigned WD_SHORT_CYCLES = WD_SHORT_MS * 1000 * CLK_MHZ;
    localparam int unsigned WD_LONG_CYCLES  = WD_LONG_MS * 1000 * CLK_MHZ;
    localparam int unsigned RST_PULSE_NS    = 80;
    localparam int unsigned RST_PULSE_CYC   = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RANGE_MIN_MHZ   = 50;
    localparam int unsigned RANGE_MAX_MHZ   = 248;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_SELECT  = 8'h08;
    localparam logic [7:0] OFS_WDOG    = 8'h09;
    localparam logic [7:0] OFS_CPU_N   = 8'h0A;
    localparam logic [7:0] OFS_CPU_M   = 8'h0B;
    localparam logic [7:0] OFS_RCV_N   = 8'h0C;
    localparam logic [7:0] OFS_RCV_M   = 8'h0D;
    localparam logic [7:0] OFS_STATUS  = 8'h0E;
    localparam logic [7:0] OFS_TEST    = 8'h0F;
    localparam logic [7:0] OFS_RSVD_A  = 8'h10;
    localparam logic [7:0] OFS_RSVD_B  = 8'h11;

    // Field positions
    localparam int unsigned BIT_BYPASS   = 7;
    localparam int unsigned BIT_WATCHDOG_ENABLE    = 7;
    localparam int unsigned BIT_WD_FLAG  = 6;
    localparam int unsigned BIT_WD_SCALE = 5;
    localparam int unsigned BIT_PROG_EN  = 7;
    localparam int unsigned BIT_RCV_SRC  = 7;

    // Reset values
    localparam logic [1:0] TEST_RESET  = 2'h3;
    localparam logic [4:0] SEL_RESET   = 5'h00;
    localparam logic [4:0] TIMER_RESET = 5'h00;

    // ----------------------------------------------------------------
    // Frequency lookup, 100 kHz units
    // ----------------------------------------------------------------
    localparam logic [22:0] GEAR_CONST = 23'h4940E5;  // 48.00741 scaled by 1e5

    localparam logic [11:0] CPU_TABLE [32] = '{
        12'h3EF, 12'h3F1, 12'h438, 12'h3F4, 12'h474, 12'h492, 12'h4B0, 12'h4CE,
        12'h4EC, 12'h514, 12'h53B, 12'h53E, 12'h541, 12'h5C8, 12'h5F0, 12'h618,
        12'h640, 12'h668, 12'h68A, 12'h6A4, 12'h6D6, 12'h708, 12'h73A, 12'h76C,
        12'h684, 12'h3EA, 12'h538, 12'h7D4, 12'h682, 12'h3E8, 12'h7D0, 12'h535};
    localparam logic [11:0] MID_TABLE [32] = '{
        12'h29F, 12'h2A1, 12'h2D0, 12'h2A3, 12'h2F8, 12'h30C, 12'h320, 12'h334,
        12'h276, 12'h28A, 12'h29E, 12'h29F, 12'h2A1, 12'h2E4, 12'h2F8, 12'h30C,
        12'h320, 12'h334, 12'h29D, 12'h2A8, 12'h2BC, 12'h2D0, 12'h2E4, 12'h2F8,
        12'h29B, 12'h29C, 12'h29C, 12'h29C, 12'h29A, 12'h29A, 12'h29A, 12'h29A};
    localparam logic [11:0] PCI_TABLE [32] = '{
        12'h150, 12'h150, 12'h168, 12'h151, 12'h17C, 12'h186, 12'h190, 12'h19A,
        12'h13B, 12'h145, 12'h14F, 12'h150, 12'h150, 12'h172, 12'h17C, 12'h186,
        12'h190, 12'h19A, 12'h14F, 12'h154, 12'h15E, 12'h168, 12'h172, 12'h17C,
        12'h14E, 12'h14E, 12'h14E, 12'h14E, 12'h14D, 12'h14D, 12'h14D, 12'h14D};

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        WD_IDLE   = 2'h0,
        WD_COUNT  = 2'h1,
        WD_EXPIRE = 2'h3
    } wd_state_type;

    typedef struct packed {
        logic [11:0] cpu_freq;
        logic [11:0] mid_freq;
        logic [11:0] pci_freq;
        logic [22:0] gear;
        logic        prog_mode;
        logic [7:0]  pll_n;
        logic [6:0]  pll_m;
    } freq_out_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

endpackage

//--- hdl/freq_select_watchdog_recovery.sv
// Purpose : Frequency select decode and watchdog recovery control
// Assumes : Byte register port is driven by the management bus engine on ref_clk
// Notes   : Strap pins are synchronised and latched once after reset release
// Functional notes
// RULE1 - Decode 5-bit code through 32-entry table
// RULE2 - Test byte resets 0x03, host writes ones
// RULE3 - Programmed CPU settings accepted, 50 to 248; the code stores any CPU N and M value with no range check
// RULE4 - Software may arm watchdog before changes
// RULE5 - Watchdog expiry asserts system reset output
// RULE6 - Expiry switches outputs to recovery frequency
// RULE7 - Enable clear stops, set counts after change
// RULE8 - Time-out flag sticky, write one clears
// RULE9 - Recovery source: straps or programmed N/M
// RULE10 - Bypass bit picks straps or register code
// RULE11 - Reserved bits read zero, writes ignored
`timescale 1ns/1ps
module freq_select_watchdog_recovery #(
    parameter int unsigned SHORT_CYCLES = freq_ctl_pkg::WD_SHORT_CYCLES,
    parameter int unsigned LONG_CYCLES  = freq_ctl_pkg::WD_LONG_CYCLES
) (
    input  wire logic                       ref_clk,
    input  wire logic                       reset_n,
    input  wire logic [4:0]                 strap_select_pins,
    input  wire freq_ctl_pkg::reg_req_type  reg_req,
    output logic [7:0]                      reg_rdata,
    output freq_ctl_pkg::freq_out_type      freq_out,
    output logic                            recovery_active,
    output logic                            sys_reset_n
);

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    logic [4:0] strap_meta_q, strap_sync_q, strap_latch_q, strap_latch_d;
    logic       strap_done_q, strap_done_d;

    always_comb begin
        strap_latch_d = strap_latch_q;
        strap_done_d  = 1'b1;
        if (!strap_done_q) begin
            strap_latch_d = strap_sync_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        strap_meta_q <= strap_select_pins;
        strap_sync_q <= strap_meta_q;
        if (!reset_n) begin
            strap_latch_q <= 5'h00;
            strap_done_q  <= 1'b0;
        end else begin
            strap_latch_q <= strap_latch_d;
            strap_done_q  <= strap_done_d;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    logic       bypass_q, bypass_d;
    logic [4:0] sel_code_q, sel_code_d;
    logic       watchdog_enable_q, watchdog_enable_d;
    logic       timeout_flag_q, timeout_flag_d;
    logic       long_scale_q, long_scale_d;
    logic [4:0] wd_timer_q, wd_timer_d;
    logic [7:0] cpu_n_q, cpu_n_d;
    logic       prog_en_q, prog_en_d;
    logic [6:0] cpu_m_q, cpu_m_d;
    logic [7:0] rcv_n_q, rcv_n_d;
    logic       recovery_source_select_q, recovery_source_select_d;
    logic [6:0] rcv_m_q, rcv_m_d;
    logic [1:0] test_q, test_d;
    logic [7:0] rdata_q, rdata_d;
    logic       recovery_q, recovery_d;
    logic [7:0] rst_cnt_q, rst_cnt_d;
    logic       freq_change;
    logic       expire;

    // Any write to the select, CPU N or CPU M register counts as a change
    assign freq_change = reg_req.wr && (reg_req.addr == freq_ctl_pkg::OFS_SELECT
                                     || reg_req.addr == freq_ctl_pkg::OFS_CPU_N
                                     || reg_req.addr == freq_ctl_pkg::OFS_CPU_M);

    always_comb begin
        bypass_d                 = bypass_q;
        sel_code_d               = sel_code_q;
        watchdog_enable_d        = watchdog_enable_q;
        timeout_flag_d           = timeout_flag_q;
        long_scale_d             = long_scale_q;
        wd_timer_d               = wd_timer_q;
        cpu_n_d                  = cpu_n_q;
        prog_en_d                = prog_en_q;
        cpu_m_d                  = cpu_m_q;
        rcv_n_d                  = rcv_n_q;
        recovery_source_select_d = recovery_source_select_q;
        rcv_m_d                  = rcv_m_q;
        test_d                   = test_q;
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                freq_ctl_pkg::OFS_SELECT: begin
                    bypass_d   = reg_req.wdata[freq_ctl_pkg::BIT_BYPASS];
                    sel_code_d = reg_req.wdata[4:0];
                end
                freq_ctl_pkg::OFS_WDOG: begin
                    watchdog_enable_d = reg_req.wdata[freq_ctl_pkg::BIT_WATCHDOG_ENABLE];
                    long_scale_d      = reg_req.wdata[freq_ctl_pkg::BIT_WD_SCALE];
                    wd_timer_d        = reg_req.wdata[4:0];
                    if (reg_req.wdata[freq_ctl_pkg::BIT_WD_FLAG]) begin
                        timeout_flag_d = 1'b0;  // see RULE8
                    end
                end
                freq_ctl_pkg::OFS_CPU_N: cpu_n_d = reg_req.wdata;  // see RULE3
                freq_ctl_pkg::OFS_CPU_M: begin
                    prog_en_d = reg_req.wdata[freq_ctl_pkg::BIT_PROG_EN];
                    cpu_m_d   = reg_req.wdata[6:0];  // see RULE3
                end
                freq_ctl_pkg::OFS_RCV_N: rcv_n_d = reg_req.wdata;
                freq_ctl_pkg::OFS_RCV_M: begin
                    recovery_source_select_d = reg_req.wdata[freq_ctl_pkg::BIT_RCV_SRC];
                    rcv_m_d                  = reg_req.wdata[6:0];
                end
                freq_ctl_pkg::OFS_TEST: test_d = reg_req.wdata[1:0];  // see RULE2
                default: begin
                end
            endcase
        end
        if (expire) begin
            timeout_flag_d = 1'b1;  // see RULE8
        end
    end

    // ----------------------------------------------------------------
    // Read back
    // ----------------------------------------------------------------
    always_comb begin
        rdata_d = rdata_q;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                freq_ctl_pkg::OFS_SELECT: rdata_d = {bypass_q, 2'h0, sel_code_q};
                freq_ctl_pkg::OFS_WDOG:   rdata_d = {watchdog_enable_q, timeout_flag_q, long_scale_q, wd_timer_q};
                freq_ctl_pkg::OFS_CPU_N:  rdata_d = cpu_n_q;
                freq_ctl_pkg::OFS_CPU_M:  rdata_d = {prog_en_q, cpu_m_q};
                freq_ctl_pkg::OFS_RCV_N:  rdata_d = rcv_n_q;
                freq_ctl_pkg::OFS_RCV_M:  rdata_d = {recovery_source_select_q, rcv_m_q};
                freq_ctl_pkg::OFS_STATUS: rdata_d = {recovery_q, ~sys_reset_n, 1'b0, strap_latch_q};
                freq_ctl_pkg::OFS_TEST:   rdata_d = {6'h00, test_q};  // see RULE11
                default:                  rdata_d = 8'h00;  // see RULE11
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Recovery and system reset
    // ----------------------------------------------------------------
    always_comb begin
        recovery_d = recovery_q;
        rst_cnt_d  = rst_cnt_q;
        if (freq_change) begin
            recovery_d = 1'b0;
        end
        if (expire) begin
            recovery_d = 1'b1;  // see RULE6
            rst_cnt_d  = 8'(freq_ctl_pkg::RST_PULSE_CYC);  // see RULE5
        end else if (rst_cnt_q != 8'h00) begin
            rst_cnt_d = rst_cnt_q - 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            bypass_q                 <= 1'b0;
            sel_code_q               <= freq_ctl_pkg::SEL_RESET;
            watchdog_enable_q        <= 1'b0;
            timeout_flag_q           <= 1'b0;
            long_scale_q             <= 1'b0;
            wd_timer_q               <= freq_ctl_pkg::TIMER_RESET;
            cpu_n_q                  <= 8'h00;
            prog_en_q                <= 1'b0;
            cpu_m_q                  <= 7'h00;
            rcv_n_q                  <= 8'h00;
            recovery_source_select_q <= 1'b0;
            rcv_m_q                  <= 7'h00;
            test_q                   <= freq_ctl_pkg::TEST_RESET;  // see RULE2
            rdata_q                  <= 8'h00;
            recovery_q               <= 1'b0;
            rst_cnt_q                <= 8'h00;
        end else begin
            bypass_q                 <= bypass_d;
            sel_code_q               <= sel_code_d;
            watchdog_enable_q        <= watchdog_enable_d;
            timeout_flag_q           <= timeout_flag_d;
            long_scale_q             <= long_scale_d;
            wd_timer_q               <= wd_timer_d;
            cpu_n_q                  <= cpu_n_d;
            prog_en_q                <= prog_en_d;
            cpu_m_q                  <= cpu_m_d;
            rcv_n_q                  <= rcv_n_d;
            recovery_source_select_q <= recovery_source_select_d;
            rcv_m_q                  <= rcv_m_d;
            test_q                   <= test_d;
            rdata_q                  <= rdata_d;
            recovery_q               <= recovery_d;
            rst_cnt_q                <= rst_cnt_d;
        end
    end

    assign reg_rdata   = rdata_q;
    assign sys_reset_n = (rst_cnt_q == 8'h00);  // see RULE5
    assign recovery_active = recovery_q;

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    watchdog_timer #(
        .SHORT_CYCLES (SHORT_CYCLES),
        .LONG_CYCLES  (LONG_CYCLES)
    ) u_watchdog (
        .ref_clk     (ref_clk),
        .reset_n     (reset_n),
        .enable      (watchdog_enable_q),
        .start       (freq_change),  // see RULE7
        .long_scale  (long_scale_q),
        .timer_value (wd_timer_q),
        .expire      (expire)
    );

    // ----------------------------------------------------------------
    // Frequency decode
    // ----------------------------------------------------------------
    logic [4:0]                 code;
    freq_ctl_pkg::freq_out_type out_q, out_d;

    always_comb begin
        code = bypass_q ? sel_code_q : strap_latch_q;  // see RULE10
        if (recovery_q && !recovery_source_select_q) begin
            code = strap_latch_q;  // see RULE9
        end
        out_d.cpu_freq  = freq_ctl_pkg::CPU_TABLE[code];  // see RULE1
        out_d.mid_freq  = freq_ctl_pkg::MID_TABLE[code];
        out_d.pci_freq  = freq_ctl_pkg::PCI_TABLE[code];
        out_d.gear      = freq_ctl_pkg::GEAR_CONST;
        out_d.prog_mode = prog_en_q;
        out_d.pll_n     = cpu_n_q;
        out_d.pll_m     = cpu_m_q;
        if (recovery_q) begin
            out_d.prog_mode = recovery_source_select_q;  // see RULE6
            out_d.pll_n     = rcv_n_q;
            out_d.pll_m     = rcv_m_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            out_q <= '0;
        end else begin
            out_q <= out_d;
        end
    end

    assign freq_out = out_q;

endmodule

//--- hdl/watchdog_timer.sv
// Purpose : Watchdog down-counter with selectable prescaler
// Assumes : start is a one-cycle pulse on a frequency change
// Notes   : Tick lengths are parameters so simulation can shorten them
`timescale 1ns/1ps
module watchdog_timer #(
    parameter int unsigned SHORT_CYCLES = freq_ctl_pkg::WD_SHORT_CYCLES,
    parameter int unsigned LONG_CYCLES  = freq_ctl_pkg::WD_LONG_CYCLES
) (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       enable,
    input  wire logic       start,
    input  wire logic       long_scale,
    input  wire logic [4:0] timer_value,
    output logic            expire
);

    freq_ctl_pkg::wd_state_type state_q, state_d;
    logic [31:0] tick_q, tick_d;
    logic [5:0]  count_q, count_d;

    always_comb begin
        state_d = state_q;
        tick_d  = tick_q;
        count_d = count_q;
        unique case (state_q)
            freq_ctl_pkg::WD_IDLE: begin
                if (enable && start) begin
                    state_d = freq_ctl_pkg::WD_COUNT;
                    tick_d  = (long_scale ? LONG_CYCLES : SHORT_CYCLES) - 32'h1;
                    count_d = {1'b0, timer_value} + 6'h01;
                end
            end
            freq_ctl_pkg::WD_COUNT: begin
                if (tick_q == 32'h0) begin
                    tick_d  = (long_scale ? LONG_CYCLES : SHORT_CYCLES) - 32'h1;
                    count_d = count_q - 6'h01;
                    if (count_q == 6'h01) begin
                        state_d = freq_ctl_pkg::WD_EXPIRE;
                    end
                end else begin
                    tick_d = tick_q - 32'h1;
                end
            end
            freq_ctl_pkg::WD_EXPIRE: begin
                state_d = freq_ctl_pkg::WD_IDLE;
            end
            default: begin
                state_d = freq_ctl_pkg::WD_IDLE;
            end
        endcase
        if (!enable) begin
            state_d = freq_ctl_pkg::WD_IDLE;  // see RULE7
            tick_d  = 32'h0;
            count_d = 6'h00;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_q <= freq_ctl_pkg::WD_IDLE;
            tick_q  <= 32'h0;
            count_q <= 6'h00;
        end else begin
            state_q <= state_d;
            tick_q  <= tick_d;
            count_q <= count_d;
        end
    end

    assign expire = (state_q == freq_ctl_pkg::WD_EXPIRE);

endmodule
